// ===== sit_map.svh
// Purpose: constants of the sensor i2c target port
// Assumes: included by bare name after the package
// Notes:   times are in their own units, cycle counts derive from them
`ifndef SIT_MAP_SVH
`define SIT_MAP_SVH

`define SIT_ADDR_W          7
`define SIT_ADDR_DEFAULT    7'h18
`define SIT_ADDR_ALT        7'h19
`define SIT_START_ADDR      8'h00
`define SIT_WDT_CFG_OFFSET  8'h34
`define SIT_RW_BIT          0
`define SIT_ACK_SLOT        4'h8
`define SIT_SYNC_RST        7'h03

`define SIT_CLK_PERIOD_NS   10
`define SIT_NS_PER_MS       1000000
`define SIT_WDT_SHORT_MS    1
`define SIT_WDT_LONG_MS     50
`define SIT_WDT_SHORT_CYC   (`SIT_WDT_SHORT_MS * `SIT_NS_PER_MS / `SIT_CLK_PERIOD_NS)
`define SIT_WDT_LONG_CYC    (`SIT_WDT_LONG_MS * `SIT_NS_PER_MS / `SIT_CLK_PERIOD_NS)
`define SIT_WDT_CNT_W       23

`endif

// ===== sit_pkg.sv
// Purpose: types of the sensor i2c target port
// Assumes: nothing
// Notes:   numbers live in sit_map.svh
package sit_pkg;

    typedef enum logic [1:0] {
        SIT_PROTO_SPI  = 2'b00,
        SIT_PROTO_I2C  = 2'b01,
        SIT_PROTO_SOLO = 2'b10
    } sit_proto_t;

    typedef enum logic [2:0] {
        SIT_L_ADDR   = 3'b000,
        SIT_L_REG    = 3'b001,
        SIT_L_WDATA  = 3'b010,
        SIT_L_READ   = 3'b011,
        SIT_L_IGNORE = 3'b100
    } sit_lstate_t;

    typedef enum logic [1:0] {
        SIT_EV_REGADDR = 2'b00,
        SIT_EV_WDATA   = 2'b01,
        SIT_EV_RDFIRST = 2'b10,
        SIT_EV_RDNEXT  = 2'b11
    } sit_ev_t;

endpackage

// ===== sit_sync3.sv
// Purpose: three-flop synchroniser with agreement filter
// Assumes: d is asynchronous to clk
// Notes:   q moves per bit only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module sit_sync3 #(
    parameter int unsigned  W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    wire  [W-1:0] agree = ~(s2_r ^ s3_r);

    generate
        if (W < 1) begin : g_bad_w
            $error("sit_sync3: W must be at least 1");
        end
    endgenerate

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_r <= RST;
            s2_r <= RST;
            s3_r <= RST;
            q    <= RST;
        end else if (ce) begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q    <= (agree & s3_r) | (~agree & q);
        end
    end
endmodule
`default_nettype wire

// ===== sit_wdt.sv
// Purpose: lock-up timer for the target port
// Assumes: hold is already synchronised to clk
// Notes:   counts only while the port itself pulls the data line low
`timescale 1ns/100ps
`default_nettype none
`include "sit_map.svh"
module sit_wdt #(
    parameter int unsigned SHORT_CYC = `SIT_WDT_SHORT_CYC,
    parameter int unsigned LONG_CYC  = `SIT_WDT_LONG_CYC,
    parameter int unsigned CNT_W     = `SIT_WDT_CNT_W
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    input  wire logic wdt_en,
    input  wire logic wdt_sel,
    input  wire logic hold,
    output var  logic trip
);
    localparam logic [CNT_W-1:0] SHORT_LIM = CNT_W'(SHORT_CYC - 1);
    localparam logic [CNT_W-1:0] LONG_LIM  = CNT_W'(LONG_CYC - 1);

    logic [CNT_W-1:0] cnt_r;
    wire  [CNT_W-1:0] limit    = wdt_sel ? LONG_LIM : SHORT_LIM;
    wire              armed    = wdt_en & hold;
    wire              at_limit = cnt_r == limit;
    wire  [CNT_W-1:0] cnt_nxt  = (armed && !at_limit) ? cnt_r + 1'b1 : '0;

    generate
        if (SHORT_CYC < 2 || LONG_CYC < 2 || LONG_CYC > 2**CNT_W) begin : g_bad
            $error("sit_wdt: timeout counts do not fit the counter");
        end
    endgenerate

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= '0;
            trip  <= 1'b0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            trip  <= armed & at_limit;
        end
    end
endmodule
`default_nettype wire

// ===== sit_target.sv
// Purpose: i2c target port in front of a sensor register file
// Assumes: serial_clock_pin clocks the bit logic; clk runs at 100 MHz
// Notes:   start/stop seen in clk domain, which holds the bit logic in reset
`timescale 1ns/100ps
`default_nettype none
`include "sit_map.svh"
module sit_target #(
    parameter int unsigned WDT_SHORT_CYC = `SIT_WDT_SHORT_CYC,
    parameter int unsigned WDT_LONG_CYC  = `SIT_WDT_LONG_CYC
) (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic               ce,
    input  wire logic               serial_clock_pin,
    input  wire logic               serial_data_pin_in,
    output var  logic               serial_data_pin_out,
    output var  logic               serial_data_pin_oe,
    input  wire logic               addr_strap_pin,
    input  wire logic [1:0]         protocol_select_pin,
    input  wire logic               wdt_en,
    input  wire logic               wdt_sel,
    output var  sit_pkg::sit_proto_t proto_mode,
    output var  logic               bus_busy,
    output var  logic               wdt_fired,
    output var  logic [7:0]         reg_addr,
    output var  logic               reg_wr_en,
    output var  logic [7:0]         reg_wr_data,
    output var  logic               reg_rd_en,
    input  wire logic [7:0]         reg_rd_data
);
    import sit_pkg::*;

    // pad sensor code: 00 ground, 01 supply, 1x floating
    function automatic sit_proto_t proto_decode(input logic [1:0] code);
        sit_proto_t m;
        m = SIT_PROTO_SOLO;
        if (code == 2'b00) begin
            m = SIT_PROTO_SPI;
        end else if (code == 2'b01) begin
            m = SIT_PROTO_I2C;
        end
        return m;
    endfunction

    // clk domain state
    logic                  sda_prev_r;
    logic                  busy_r;
    logic                  low_seen_r;
    logic                  start_hold_r;
    logic                  dead_r;
    logic                  link_rst_r;
    logic                  tgl_prev_r;
    logic                  addr_sel_r;
    logic                  rd_pend_r;
    logic [7:0]            base_r;
    logic [7:0]            ptr_r;
    logic [7:0]            rd_byte_r;
    sit_proto_t            proto_r;

    // link domain state
    logic [3:0]            bit_cnt_r;
    logic [7:0]            shift_r;
    sit_lstate_t           state_r;
    sit_lstate_t           state_nxt;
    logic                  sda_oe_r;
    logic                  ev_tgl_r;
    sit_ev_t               ev_code_r;
    logic [7:0]            ev_data_r;
    logic                  ev_fire;
    sit_ev_t               ev_code_nxt;

    // synchronised inputs
    logic [6:0]            sync_q;
    logic                  wdt_trip;
    wire                   scl_s   = sync_q[0];
    wire                   sda_s   = sync_q[1];
    wire                   tgl_s   = sync_q[2];
    wire                   oe_s    = sync_q[3];
    wire                   strap_s = sync_q[4];
    wire  [1:0]            psel_s  = sync_q[6:5];

    sit_sync3 #(
        .W   (7),
        .RST (`SIT_SYNC_RST)
    ) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .d       ({protocol_select_pin, addr_strap_pin, sda_oe_r, ev_tgl_r,
                   serial_data_pin_in, serial_clock_pin}),
        .q       (sync_q)
    );

    sit_wdt #(
        .SHORT_CYC (WDT_SHORT_CYC),
        .LONG_CYC  (WDT_LONG_CYC)
    ) u_wdt (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .wdt_en  (wdt_en),
        .wdt_sel (wdt_sel),
        .hold    (oe_s & busy_r),
        .trip    (wdt_trip)
    );

    // bus condition decode
    wire i2c_on    = proto_r == SIT_PROTO_I2C;
    wire start_det = i2c_on & scl_s & sda_prev_r & ~sda_s;
    wire stop_edge = scl_s & ~sda_prev_r & sda_s;
    wire stop_det  = stop_edge & busy_r & low_seen_r;

    wire busy_nxt       = start_det | (busy_r & ~stop_det & i2c_on);
    wire low_seen_nxt   = ~start_det & (low_seen_r | (busy_r & ~scl_s));
    wire start_hold_nxt = start_det | (start_hold_r & scl_s);
    // a trip landing in the start cycle still wins over the clear
    wire dead_nxt       = wdt_trip | (dead_r & ~start_det);
    // bit logic restarts on every start and sleeps outside frames
    wire link_rst_nxt   = ~busy_nxt | start_hold_nxt | dead_nxt;

    // events arriving from the bit logic
    wire       ev_pulse = tgl_s ^ tgl_prev_r;
    wire       ev_rd    = ev_pulse & ev_code_r[1];
    wire       ev_wr    = ev_pulse & (ev_code_r == SIT_EV_WDATA);
    wire       ev_reg   = ev_pulse & (ev_code_r == SIT_EV_REGADDR);
    wire       ev_first = ev_code_r == SIT_EV_RDFIRST;
    wire [7:0] rd_src   = ev_first ? base_r : ptr_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sda_prev_r   <= 1'b1;
            busy_r       <= 1'b0;
            low_seen_r   <= 1'b0;
            start_hold_r <= 1'b0;
            dead_r       <= 1'b0;
            link_rst_r   <= 1'b1;
            proto_r      <= SIT_PROTO_SPI;
            addr_sel_r   <= 1'b0;
        end else if (ce) begin
            sda_prev_r   <= sda_s;
            busy_r       <= busy_nxt;
            low_seen_r   <= low_seen_nxt;
            start_hold_r <= start_hold_nxt;
            dead_r       <= dead_nxt;
            link_rst_r   <= link_rst_nxt;
            proto_r      <= proto_decode(psel_s);
            // strap only follows while idle so a frame sees one address
            if (!busy_r) begin
                addr_sel_r <= strap_s;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tgl_prev_r  <= 1'b0;
            base_r      <= `SIT_START_ADDR;
            ptr_r       <= `SIT_START_ADDR;
            reg_addr    <= `SIT_START_ADDR;
            reg_wr_data <= 8'h00;
            reg_wr_en   <= 1'b0;
            reg_rd_en   <= 1'b0;
            rd_pend_r   <= 1'b0;
            rd_byte_r   <= 8'h00;
        end else if (ce) begin
            tgl_prev_r <= tgl_s;
            reg_wr_en  <= ev_wr;
            reg_rd_en  <= ev_rd;
            rd_pend_r  <= reg_rd_en;
            if (ev_reg) begin
                base_r <= ev_data_r;
            end
            if (ev_wr) begin
                reg_addr    <= base_r;
                reg_wr_data <= ev_data_r;
            end
            if (ev_rd) begin
                reg_addr <= rd_src;
                ptr_r    <= rd_src + 8'h01;
            end
            if (rd_pend_r) begin
                rd_byte_r <= reg_rd_data;
            end
        end
    end

    assign proto_mode = proto_r;
    assign bus_busy   = busy_r;
    assign wdt_fired  = wdt_trip;

    // link domain: the bus clock itself, reset by the clk domain
    // addr_sel_r and rd_byte_r are quasi-static here: they settle long
    // before the bus edge that uses them
    wire [6:0] my_addr  = addr_sel_r ? `SIT_ADDR_ALT : `SIT_ADDR_DEFAULT;
    wire       addr_hit = shift_r[7:1] == my_addr;
    wire       is_read  = shift_r[`SIT_RW_BIT];
    wire       ack_slot = bit_cnt_r == `SIT_ACK_SLOT;
    wire       tx_bit   = rd_byte_r[~bit_cnt_r[2:0]];
    wire       rx_byte  = (state_r == SIT_L_REG) | (state_r == SIT_L_WDATA);
    wire       ack_now  = ((state_r == SIT_L_ADDR) & addr_hit) | rx_byte;
    wire       tx_now   = (state_r == SIT_L_READ) & ~tx_bit;
    wire       oe_nxt   = ack_slot ? ack_now : tx_now;

    always_comb begin
        state_nxt   = state_r;
        ev_fire     = 1'b0;
        ev_code_nxt = ev_code_r;
        if (ack_slot) begin
            case (state_r)
                SIT_L_ADDR: begin
                    if (!addr_hit) begin
                        state_nxt = SIT_L_IGNORE;
                    end else if (is_read) begin
                        state_nxt   = SIT_L_READ;
                        ev_fire     = 1'b1;
                        ev_code_nxt = SIT_EV_RDFIRST;
                    end else begin
                        state_nxt = SIT_L_REG;
                    end
                end
                SIT_L_REG: begin
                    state_nxt   = SIT_L_WDATA;
                    ev_fire     = 1'b1;
                    ev_code_nxt = SIT_EV_REGADDR;
                end
                SIT_L_WDATA: begin
                    // one data byte per write; further bytes get no ack
                    state_nxt   = SIT_L_IGNORE;
                    ev_fire     = 1'b1;
                    ev_code_nxt = SIT_EV_WDATA;
                end
                SIT_L_READ: begin
                    if (serial_data_pin_in) begin
                        state_nxt = SIT_L_IGNORE;
                    end else begin
                        ev_fire     = 1'b1;
                        ev_code_nxt = SIT_EV_RDNEXT;
                    end
                end
                default: begin
                    state_nxt = SIT_L_IGNORE;
                end
            endcase
        end
    end

    always_ff @(posedge serial_clock_pin or posedge link_rst_r) begin
        if (link_rst_r) begin
            bit_cnt_r <= 4'h0;
            shift_r   <= 8'h00;
            state_r   <= SIT_L_ADDR;
        end else begin
            bit_cnt_r <= ack_slot ? 4'h0 : bit_cnt_r + 4'h1;
            state_r   <= state_nxt;
            if (!ack_slot) begin
                shift_r <= {shift_r[6:0], serial_data_pin_in};
            end
        end
    end

    // event carriers must survive frame resets or parity would slip
    always_ff @(posedge serial_clock_pin or posedge sys_rst) begin
        if (sys_rst) begin
            ev_tgl_r  <= 1'b0;
            ev_code_r <= SIT_EV_REGADDR;
            ev_data_r <= 8'h00;
        end else if (ev_fire) begin
            ev_tgl_r  <= ~ev_tgl_r;
            ev_code_r <= ev_code_nxt;
            ev_data_r <= shift_r;
        end
    end

    // drive on the falling edge so data is stable through the high phase
    always_ff @(negedge serial_clock_pin or posedge link_rst_r) begin
        if (link_rst_r) begin
            sda_oe_r <= 1'b0;
        end else begin
            sda_oe_r <= oe_nxt;
        end
    end

    assign serial_data_pin_out = 1'b0;
    assign serial_data_pin_oe  = sda_oe_r;
endmodule
`default_nettype wire

// ===== sit_target_checker.sv
// Purpose: concurrent checks on the i2c target port
// Assumes: lock-up limits equal those of the bound instance
// Notes:   bound into sit_target at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module sit_target_checker #(
    parameter int unsigned WDT_SHORT_CYC = 20,
    parameter int unsigned WDT_LONG_CYC  = 50
) (
    input wire logic                clk,
    input wire logic                sys_rst,
    input wire logic                serial_clock_pin,
    input wire logic                serial_data_pin_in,
    input wire logic                serial_data_pin_out,
    input wire logic                serial_data_pin_oe,
    input wire logic                wdt_en,
    input wire logic                wdt_sel,
    input wire sit_pkg::sit_proto_t proto_mode,
    input wire logic                bus_busy,
    input wire logic                wdt_fired,
    input wire logic                reg_wr_en,
    input wire logic                reg_rd_en
);
    import sit_pkg::*;

    logic [31:0] hold_cnt_r;
    logic [31:0] lim;

    assign lim = wdt_sel ? WDT_LONG_CYC : WDT_SHORT_CYC;

    // kept over short drops so synchroniser lag cannot fake an early trip
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_cnt_r <= '0;
        end else if (serial_data_pin_oe) begin
            hold_cnt_r <= hold_cnt_r + 32'h0000_0001;
        end else if (!$past(serial_data_pin_oe, 4)) begin
            hold_cnt_r <= '0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_out_low: assert property (serial_data_pin_out == 1'b0)
        else $error("data pin output not low");
    a_wr_one_pulse: assert property (reg_wr_en |=> !reg_wr_en)
        else $error("write strobe longer than one cycle");
    a_rd_one_pulse: assert property (reg_rd_en |=> !reg_rd_en)
        else $error("read strobe longer than one cycle");
    a_wr_in_frame: assert property (
        reg_wr_en |-> bus_busy && proto_mode == SIT_PROTO_I2C)
        else $error("write outside an i2c frame");
    a_rd_in_frame: assert property (
        reg_rd_en |-> bus_busy && proto_mode == SIT_PROTO_I2C)
        else $error("read outside an i2c frame");
    a_drive_in_frame: assert property ($rose(serial_data_pin_oe) |-> bus_busy)
        else $error("data driven while bus idle");
    a_busy_on_start: assert property (
        $rose(bus_busy) |-> serial_clock_pin && !serial_data_pin_in)
        else $error("busy rose without start");
    a_busy_on_stop: assert property (
        $fell(bus_busy) |-> serial_clock_pin && serial_data_pin_in)
        else $error("busy fell without stop");
    a_wdt_enabled: assert property (wdt_fired |-> wdt_en)
        else $error("lock-up timer fired while disabled");
    a_wdt_period: assert property (wdt_fired |-> hold_cnt_r >= lim)
        else $error("lock-up timer fired early");
    a_wdt_release: assert property (wdt_fired |-> ##[1:6] !serial_data_pin_oe)
        else $error("data line kept low after lock-up");

    c_write: cover property (reg_wr_en);
    c_read: cover property (reg_rd_en);
    c_lockup: cover property (wdt_fired);
    c_stop: cover property ($fell(bus_busy));
endmodule

bind sit_target sit_target_checker #(
    .WDT_SHORT_CYC(WDT_SHORT_CYC),
    .WDT_LONG_CYC (WDT_LONG_CYC)
) u_chk (
    .clk(clk), .sys_rst(sys_rst), .serial_clock_pin(serial_clock_pin),
    .serial_data_pin_in(serial_data_pin_in), .serial_data_pin_out(serial_data_pin_out),
    .serial_data_pin_oe(serial_data_pin_oe), .wdt_en(wdt_en), .wdt_sel(wdt_sel),
    .proto_mode(proto_mode), .bus_busy(bus_busy), .wdt_fired(wdt_fired),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en)
);
`default_nettype wire

// ===== sit_i2c_master.sv
// Purpose: behavioural i2c bus master facing the target port
// Assumes: data wire has a pull-up; m_oe high pulls it low
// Notes:   bus clock stands high between frames
`timescale 1ns/100ps
`default_nettype none
module sit_i2c_master (
    output var  logic scl,
    output var  logic m_oe,
    input  wire logic sda
);
    // quarter bit; keeps low >= 1.3 us and high >= 0.6 us
    localparam int Q = 653;

    initial begin
        scl  = 1'b1;
        m_oe = 1'b0;
    end

    task automatic bit_io(input logic b, output logic seen);
        scl  = 1'b0;
        #Q;
        m_oe = ~b;
        #Q;
        scl  = 1'b1;
        #Q;
        seen = sda;
        #Q;
    endtask

    task automatic start();
        if (sda !== 1'b1) begin
            scl  = 1'b0;
            #Q;
            m_oe = 1'b0;
            #Q;
            scl  = 1'b1;
            #Q;
        end
        m_oe = 1'b1;
        #Q;
    endtask

    task automatic stop();
        scl  = 1'b0;
        #Q;
        m_oe = 1'b1;
        #Q;
        scl  = 1'b1;
        #Q;
        m_oe = 1'b0;
        #(2 * Q);
    endtask

    // only on a scenario's order: stop straight after start
    task automatic bare_stop();
        #Q;
        m_oe = 1'b0;
        #Q;
    endtask

    task automatic wbits(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
    endtask

    task automatic wbyte(input logic [7:0] b, output logic ack);
        wbits(b);
        bit_io(1'b1, ack);
    endtask

    task automatic rbyte(input logic mack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            b[i] = s;
        end
        bit_io(mack, s);
    endtask

    // stalls the bus clock low, as a hung master would
    task automatic hold_low();
        scl = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// Purpose: self-checking bench for the i2c target port
// Assumes: lock-up counts shortened to 20 and 50 cycles
// Notes:   fake register file returns address xor 0x5a
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import sit_pkg::*;

    localparam int SHORT = 20;
    localparam int LONG  = 50;
    localparam int LIMIT = 90000;

    logic       clk;
    logic       sys_rst;
    logic       ce;
    logic       strap;
    logic [1:0] psel;
    logic       wdt_en;
    logic       wdt_sel;
    logic [7:0] rd_data;
    logic [7:0] wr_a;
    logic [7:0] wr_d;
    int         wr_cnt = 0;
    int         fire_cnt = 0;
    int         cycles = 0;
    int         fail_count = 0;
    int         compares = 0;
    wire        scl;
    wire        m_oe;
    wire        dev_oe;
    wire        busy;
    wire        fired;
    wire        wr_en;
    wire [7:0]  addr;
    wire [7:0]  wdata;
    wire        sda;
    sit_proto_t mode;

    assign sda = ~(m_oe | dev_oe);

    sit_i2c_master mst (.scl(scl), .m_oe(m_oe), .sda(sda));

    sit_target #(.WDT_SHORT_CYC(SHORT), .WDT_LONG_CYC(LONG)) uut (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .serial_clock_pin(scl),
        .serial_data_pin_in(sda), .serial_data_pin_out(), .serial_data_pin_oe(dev_oe),
        .addr_strap_pin(strap), .protocol_select_pin(psel), .wdt_en(wdt_en),
        .wdt_sel(wdt_sel), .proto_mode(mode), .bus_busy(busy), .wdt_fired(fired),
        .reg_addr(addr), .reg_wr_en(wr_en), .reg_wr_data(wdata), .reg_rd_en(),
        .reg_rd_data(rd_data)
    );

    always #5 clk = ~clk;

    always @(negedge clk) rd_data <= addr ^ 8'h5a;

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (wr_en === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            wr_a   <= addr;
            wr_d   <= wdata;
        end
        if (fired === 1'b1) fire_cnt <= fire_cnt + 1;
        if (cycles == LIMIT) begin
            fail_count++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (fail_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic t_proto();
        sit_proto_t pexp [4];
        logic       a;
        pexp = '{SIT_PROTO_SPI, SIT_PROTO_I2C, SIT_PROTO_SOLO, SIT_PROTO_SOLO};
        for (int i = 0; i < 4; i++) begin
            psel = 2'(i);
            repeat (10) @(negedge clk);
            check(mode, pexp[i]);
        end
        psel = 2'b00;
        repeat (10) @(negedge clk);
        mst.start();
        mst.wbyte(8'h30, a);
        mst.stop();
        check(a, 1'b1);
        @(negedge clk);
        psel = 2'b01;
        repeat (10) @(negedge clk);
        ce   = 1'b0;
        psel = 2'b11;
        repeat (10) @(negedge clk);
        check(mode, SIT_PROTO_I2C);
        ce = 1'b1;
        repeat (10) @(negedge clk);
        check(mode, SIT_PROTO_SOLO);
        psel = 2'b01;
        repeat (10) @(negedge clk);
    endtask

    task automatic t_read_dflt();
        logic       a;
        logic [7:0] b;
        mst.start();
        repeat (10) @(negedge clk);
        check(busy, 1'b1);
        mst.wbyte(8'h31, a);
        check(a, 1'b0);
        mst.rbyte(1'b0, b);
        check(b, 8'h5a);
        mst.rbyte(1'b1, b);
        check(b, 8'h5b);
        mst.stop();
        check(busy, 1'b0);
    endtask

    task automatic t_write();
        logic [2:0] a;
        int         n;
        n = wr_cnt;
        mst.start();
        mst.wbyte(8'h30, a[2]);
        mst.wbyte(8'h34, a[1]);
        mst.wbyte(8'h81, a[0]);
        mst.stop();
        check(a, 3'b000);
        check(wr_cnt, n + 1);
        check({wr_a, wr_d}, 16'h3481);
    endtask

    task automatic t_read_inc();
        logic [2:0]  a;
        logic [23:0] b;
        int          n;
        n = wr_cnt;
        mst.start();
        mst.wbyte(8'h30, a[2]);
        mst.wbyte(8'hfe, a[1]);
        mst.start();
        mst.wbyte(8'h31, a[0]);
        mst.rbyte(1'b0, b[23:16]);
        mst.rbyte(1'b0, b[15:8]);
        mst.rbyte(1'b1, b[7:0]);
        mst.stop();
        check(a, 3'b000);
        check(b, 24'ha4_a55a);
        check(wr_cnt, n);
        mst.start();
        mst.wbyte(8'h31, a[0]);
        mst.rbyte(1'b1, b[7:0]);
        mst.stop();
        check(b[7:0], 8'ha4);
    endtask

    task automatic t_start_stop();
        mst.start();
        mst.bare_stop();
        repeat (20) @(negedge clk);
        check(busy, 1'b1);
        mst.stop();
        check(busy, 1'b0);
    endtask

    task automatic t_wdt(input logic sel, input int lim);
        int n;
        @(negedge clk);
        wdt_sel = sel;
        wdt_en  = 1'b1;
        mst.start();
        mst.wbits(8'h30);
        mst.hold_low();
        for (n = 0; n < 500 && dev_oe !== 1'b1; n++) @(negedge clk);
        for (n = 0; n < 300 && fired !== 1'b1; n++) @(negedge clk);
        check(n >= lim + 1 && n <= lim + 8, 1'b1);
        repeat (8) @(negedge clk);
        check(dev_oe, 1'b0);
        mst.stop();
        @(negedge clk);
        wdt_en = 1'b0;
    endtask

    task automatic t_strap();
        logic [2:0] a;
        int         n;
        strap = 1'b1;
        repeat (10) @(negedge clk);
        n = wr_cnt;
        mst.start();
        mst.wbyte(8'h30, a[2]);
        mst.wbyte(8'h34, a[1]);
        mst.start();
        mst.wbyte(8'hf0, a[0]);
        check(a, 3'b111);
        mst.start();
        mst.wbyte(8'h32, a[2]);
        mst.wbyte(8'h10, a[1]);
        mst.wbyte(8'hab, a[0]);
        mst.stop();
        check(a, 3'b000);
        check({wr_a, wr_d}, 16'h10ab);
        check(wr_cnt, n + 1);
        check(fire_cnt, 2);
    endtask

    initial begin
        clk     = 1'b0;
        sys_rst = 1'b1;
        ce      = 1'b1;
        strap   = 1'b0;
        psel    = 2'b01;
        wdt_en  = 1'b0;
        wdt_sel = 1'b0;
        rd_data = 8'h00;
        repeat (12) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        repeat (20) @(negedge clk);
        t_proto();
        t_read_dflt();
        t_write();
        t_read_inc();
        t_start_stop();
        t_wdt(1'b0, SHORT);
        t_wdt(1'b1, LONG);
        t_strap();
        conclude();
    end
endmodule
`default_nettype wire
